// [bench/sar_bus_master.sv]
// Behavioural two-wire bus master: bus clock and open-drain data
`timescale 1ns/10ps
module sar_bus_master (
    output logic      sclLine,
    output logic      sdaPull,
    input  wire logic sdaLine
);
    // ==================================================================
    // Idle bus: clock stands high, data released to its pull-up
    initial begin
        sclLine = 1'b1;
        sdaPull = 1'b0;
    end

    // Start or repeated start: data falls while the clock is high;
    // the first wait lets the slave drop its acknowledge before the
    // clock rises, so no false STOP is seen ahead of a repeated start
    task automatic startBit();
        #35 sdaPull = 1'b0;
        #25 sclLine = 1'b1;
        #40 sdaPull = 1'b1;
        #40 sclLine = 1'b0;
    endtask

    // Stop: data rises while the clock is high, ending the transfer;
    // steps are whole core periods so no pin moves on a core edge
    task automatic stopBit();
        #10 sdaPull = 1'b1;
        #30 sclLine = 1'b1;
        #40 sdaPull = 1'b0;
        #40;
    endtask

    // One bit: long low phase so the slave answer settles before rise
    task automatic bitCycle(input logic drv, output logic seen);
        #25 sdaPull = ~drv;
        #25 sclLine = 1'b1;
        #20 seen = sdaLine;
        #10 sclLine = 1'b0;
    endtask

    // Eight bits MSB first, then the acknowledge bit
    task automatic xferByte(input  logic [7:0] txd,
                            input  logic       ackBit,
                            output logic [7:0] rxd,
                            output logic       ackSeen);
        for (int i = 7; i >= 0; i--) begin
            bitCycle(txd[i], rxd[i]);
        end
        bitCycle(ackBit, ackSeen);
    endtask
endmodule

// [bench/sar_slave_top_test.sv]
// Self-checking bench for the alert-responding two-wire slave
`timescale 1ns/10ps
module sar_slave_top_test;
    // ==================================================================
    // Signals and fixtures
    localparam logic [5:0] PIN_SET  [0:3] = '{6'h00, 6'h2A, 6'h14, 6'h09};
    localparam logic [6:0] ADDR_EXP [0:3] = '{7'h44, 7'h4A, 7'h5A, 7'h43};
    logic        core_clk    = 1'b0;
    logic        srst        = 1'b1;
    logic        sclLine;
    logic        mstPull;
    wire         sdaLine;
    logic        sdaOut;
    logic        sdaOe;
    logic        alertOut;
    logic        alertOe;
    logic [1:0]  pinLo       = 2'h0;
    logic [1:0]  pinMid      = 2'h0;
    logic [1:0]  pinHi       = 2'h0;
    logic        massWrEn    = 1'b1;
    logic [7:0]  faultFlags  = 8'h00;
    logic [7:0]  alertEnable = 8'h00;
    logic [7:0]  regs [0:7]  = '{default: 8'h00};
    logic [2:0]  regPtr;
    logic        regWrEn;
    logic [7:0]  regWrData;
    int unsigned seedVal;
    int          errCount    = 0;
    int          samplesChecked = 0;

    // Clock, open-drain data wire and the register file behind the slave
    always #5 core_clk = ~core_clk;
    assign sdaLine = ~(mstPull | sdaOe);
    always @(posedge core_clk) begin
        if (regWrEn) begin
            regs[regPtr] <= regWrData;
        end
    end

    sar_bus_master bm (.sclLine(sclLine), .sdaPull(mstPull),
                       .sdaLine(sdaLine));

    sar_slave_top uut (
        .core_clk(core_clk), .srst(srst), .sclPin(sclLine),
        .sdaPin(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .alertOut(alertOut), .alertOe(alertOe), .addrPinSelLo(pinLo),
        .addrPinSelMid(pinMid), .addrPinSelHi(pinHi),
        .massWrEn(massWrEn), .faultFlags(faultFlags),
        .alertEnable(alertEnable), .regRdData(regs[regPtr]),
        .regPtr(regPtr), .regWrEn(regWrEn), .regWrData(regWrData));

    // ==================================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    // Wait whole cycles, then step past the edge so outputs are settled
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Write transfer with n data bytes; later bytes differ from the first
    task automatic wrTx(input logic [6:0] a, input logic [7:0] c,
                        input logic [7:0] d, input int n,
                        output logic nak);
        logic [7:0] rx;
        logic       k;
        bm.startBit();
        bm.xferByte({a, 1'b0}, 1'b1, rx, nak);
        if (nak === 1'b0) begin
            bm.xferByte(c, 1'b1, rx, k);
            for (int i = 0; i < n; i++) begin
                bm.xferByte((i == 0) ? d : ~d, 1'b1, rx, k);
            end
        end
        bm.stopBit();
    endtask

    // Read word: pointer set, repeated start, two bytes, last not acked
    task automatic rdTx(input logic [6:0] a, input logic [7:0] c,
                        output logic [7:0] b1, output logic [7:0] b2);
        logic k;
        bm.startBit();
        bm.xferByte({a, 1'b0}, 1'b1, b1, k);
        bm.xferByte(c, 1'b1, b1, k);
        bm.startBit();
        bm.xferByte({a, 1'b1}, 1'b1, b1, k);
        bm.xferByte(8'hFF, 1'b0, b1, k);
        bm.xferByte(8'hFF, 1'b1, b2, k);
        bm.stopBit();
    endtask

    // Alert response read, answered byte not acknowledged
    task automatic araTx(output logic nak, output logic [7:0] b);
        logic k;
        bm.startBit();
        bm.xferByte({7'h0C, 1'b1}, 1'b1, b, nak);
        if (nak === 1'b0) begin
            bm.xferByte(8'hFF, 1'b1, b, k);
        end
        bm.stopBit();
    endtask

    task automatic printVerdict();
        $display("Checks %0d errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        logic [7:0] c, d, b1, b2;
        logic [6:0] me;
        logic       nak;
        seedVal = $urandom(32'hE77C5E01);
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        tick(1);
        check(8'({sdaOut, alertOut, sdaOe, alertOe, regPtr}), 8'h00);
        // Each pin setting: foreign address refused, write word, read word
        for (int p = 0; p < 4; p++) begin
            @(posedge core_clk);
            {pinHi, pinMid, pinLo} <= PIN_SET[p];
            tick(6);
            me = ADDR_EXP[p];
            c = 8'($urandom);
            d = 8'($urandom);
            wrTx(me ^ 7'h40, c, d, 1, nak);
            check(8'(nak), 8'h01);
            wrTx(me, c, d, 2, nak);
            check(8'(nak), 8'h00);
            check(regs[c[2:0]], d);
            check(8'(regPtr), 8'(c[2:0]));
            rdTx(me, c ^ 8'hF8, b1, b2);
            check(b1, d);
            check(b2, d);
        end
        // Mass write taken while enabled, refused once disabled
        wrTx(7'h5F, 8'h06, d ^ 8'h3C, 1, nak);
        check(regs[6], d ^ 8'h3C);
        @(posedge core_clk);
        massWrEn <= 1'b0;
        wrTx(7'h5F, 8'h06, d, 1, nak);
        check(8'(nak), 8'h01);
        // Disabled fault only: no alert, response address refused
        @(posedge core_clk);
        alertEnable <= 8'h04;
        faultFlags  <= 8'h20;
        tick(4);
        check(8'(alertOe), 8'h00);
        araTx(nak, b1);
        check(8'(nak), 8'h01);
        @(posedge core_clk);
        faultFlags <= 8'h24;
        tick(3);
        check(8'({alertOut, alertOe}), 8'h01);
        araTx(nak, b1);
        check(b1, {me, 1'b0});
        tick(1);
        check(8'(alertOe), 8'h00);
        tick(20);
        check(8'(alertOe), 8'h00);
        // A different flag alerts; own-address read releases it
        @(posedge core_clk);
        alertEnable <= 8'h0C;
        faultFlags  <= 8'h2C;
        tick(3);
        check(8'(alertOe), 8'h01);
        rdTx(me, 8'h06, b1, b2);
        check(8'(alertOe), 8'h00);
        // Original flag cleared then set again alerts once more
        @(posedge core_clk);
        faultFlags <= 8'h28;
        tick(4);
        check(8'(alertOe), 8'h00);
        @(posedge core_clk);
        faultFlags <= 8'h2C;
        tick(3);
        check(8'(alertOe), 8'h01);
        wrTx(me, 8'h01, d, 1, nak);
        check(8'(alertOe), 8'h00);
        printVerdict();
    end

    // Watchdog: well beyond the expected run of about 50 us
    initial begin
        #200000;
        errCount++;
        printVerdict();
    end
endmodule

// [core/sar_line_if.sv]
// Bus line events passed from the pin sampler to the slave engine
`timescale 1ns/10ps
interface sar_line_if;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic sdaLvl;

    modport src (output sclRise, sclFall, startCond, stopCond, sdaLvl);
    modport dst (input  sclRise, sclFall, startCond, stopCond, sdaLvl);
endinterface

// [core/sar_line_sampler.sv]
// Synchroniser and edge, START and STOP detector for the bus lines
`timescale 1ns/10ps
module sar_line_sampler (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic sclPin,
    input  wire logic sdaPin,
    sar_line_if.src   ln
);
    logic [1:0] sclSync_ff;
    logic [1:0] sdaSync_ff;
    logic       sclPrev_ff;
    logic       sdaPrev_ff;

    // ==================================================================
    // Two-stage synchronisers, idle high
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclSync_ff <= 2'h3;
            sdaSync_ff <= 2'h3;
        end else begin
            sclSync_ff <= {sclSync_ff[0], sclPin};
            sdaSync_ff <= {sdaSync_ff[0], sdaPin};
        end
    end

    // Previous settled levels for edge finding
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclPrev_ff <= sclSync_ff[1];
            sdaPrev_ff <= sdaSync_ff[1];
        end
    end

    // Events: data edges while clock stays high are START or STOP
    assign ln.sclRise   = sclSync_ff[1] & ~sclPrev_ff;
    assign ln.sclFall   = ~sclSync_ff[1] & sclPrev_ff;
    assign ln.startCond = sclSync_ff[1] & sclPrev_ff
                          & ~sdaSync_ff[1] & sdaPrev_ff;
    assign ln.stopCond  = sclSync_ff[1] & sclPrev_ff
                          & sdaSync_ff[1] & ~sdaPrev_ff;
    assign ln.sdaLvl    = sdaSync_ff[1];
endmodule

// [core/sar_pkg.sv]
// Constants shared by the alert-responding two-wire slave
package sar_pkg;

    // ==================================================================
    // Address pin states and fixed addresses
    localparam logic [1:0] PIN_LOW    = 2'h0;
    localparam logic [1:0] PIN_HIGH   = 2'h1;
    localparam logic [1:0] PIN_OPEN   = 2'h2;
    localparam int         PIN_RADIX  = 3;
    localparam logic [1:0] ADDR_TOP   = 2'h2;    // Upper address bits 10
    localparam logic [6:0] MASS_ADDR  = 7'h5F;   // Broadcast write address
    localparam logic [6:0] ARA_ADDR   = 7'h0C;   // Alert response address

    // Pin code index (hi*9 + mid*3 + lo) to low five address bits
    localparam logic [4:0] ADDR_LUT [0:26] = '{
        5'h04, 5'h07, 5'h06, 5'h18, 5'h05, 5'h01, 5'h00, 5'h03, 5'h02,
        5'h14, 5'h17, 5'h16, 5'h1A, 5'h15, 5'h11, 5'h10, 5'h13, 5'h12,
        5'h0C, 5'h0F, 5'h0E, 5'h19, 5'h0D, 5'h09, 5'h08, 5'h0B, 5'h0A
    };

    // ==================================================================
    // Byte framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] BYTE_ADDR     = 2'h0;
    localparam logic [1:0] BYTE_CMD      = 2'h1;
    localparam logic [1:0] BYTE_DAT1     = 2'h2;
    localparam logic [1:0] BYTE_DAT2     = 2'h3;
    localparam int         PTR_W         = 3;
    localparam int         FLAG_W        = 8;

endpackage

// [core/sar_slave_top.sv]
// Two-wire register slave with pin address decode and alert response
// Summary of operation
// R1: The slave address is binary 10 followed by five pin-decoded bits.
// R2: Writes to 1011111 are taken too, unless mass write is disabled.
// R3: The three address pins map to one of 27 addresses by a fixed table.
// R4: After the command byte only its low three bits load the pointer.
// R5: A second written data byte is acknowledged but changes nothing.
// R6: The master ends every transfer with STOP, which ends the transfer.
// R7: A read is address-write, command, repeated START, address-read.
// R8: After our own read address the pointed register is sent, MSB first.
// R9: When the master acknowledges a register read byte, the same byte is resent.
// R10: Alert is pulled low when an enabled fault flag becomes set.
// R11: While alerting, a read to 0001100 returns our address then releases.
// R12: Being addressed in an ordinary transfer also releases the alert.
// R13: Alert returns only for another flag or a flag set again later.
// R14: Alerts follow the set edge of a flag, never its standing level.
// R15: The master not-acknowledges the alert response byte before STOP.
`timescale 1ns/10ps
module sar_slave_top (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        sclPin,
    input  wire logic        sdaPin,
    output logic             sdaOut,
    output logic             sdaOe,
    output logic             alertOut,
    output logic             alertOe,
    input  wire logic [1:0]  addrPinSelLo,
    input  wire logic [1:0]  addrPinSelMid,
    input  wire logic [1:0]  addrPinSelHi,
    input  wire logic        massWrEn,
    input  wire logic [7:0]  faultFlags,
    input  wire logic [7:0]  alertEnable,
    input  wire logic [7:0]  regRdData,
    output logic [2:0]       regPtr,
    output logic             regWrEn,
    output logic [7:0]       regWrData
);
    typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} sar_state_e;

    sar_line_if  ln ();
    sar_state_e  state_ff;
    logic [3:0]  bitCnt_ff;
    logic [7:0]  shReg_ff, txByte_ff;
    logic [1:0]  byteNo_ff;
    logic        txMode_ff, araMode_ff, mAck_ff;
    logic        sdaOe_ff, alertOe_ff, lowLvl_ff;
    logic [2:0]  regPtr_ff;
    logic        regWrEn_ff;
    logic [7:0]  regWrData_ff, flagPrev_ff;
    logic [5:0]  pinMeta_ff, pinSync_ff;
    logic [4:0]  ownAddr_ff;
    logic [1:0]  pinCode [3];
    logic [4:0]  lutIdx;
    logic        byteDone, isAddrByte, ownHit, massHit, araHit;
    logic        ackGo, araRel, rdMsb;
    logic [2:0]  cmdBits;
    logic [7:0]  araWord, txSrc, newFault;

    sar_line_sampler u_sampler (
        .core_clk (core_clk),
        .srst     (srst),
        .sclPin   (sclPin),
        .sdaPin   (sdaPin),
        .ln       (ln.src)
    );

    // ==================================================================
    // Address pins: synchronise, clamp illegal code to open, look up
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pinMeta_ff <= 6'h00;
            pinSync_ff <= 6'h00;
        end else begin
            pinMeta_ff <= {addrPinSelHi, addrPinSelMid, addrPinSelLo};
            pinSync_ff <= pinMeta_ff;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            assign pinCode[gi] = (pinSync_ff[2*gi+1 -: 2] > sar_pkg::PIN_OPEN)
                                 ? sar_pkg::PIN_OPEN
                                 : pinSync_ff[2*gi+1 -: 2];
        end
    endgenerate

    assign lutIdx = 5'(pinCode[2] * sar_pkg::PIN_RADIX * sar_pkg::PIN_RADIX
                       + pinCode[1] * sar_pkg::PIN_RADIX + pinCode[0]);

    // Own address follows the decoded pins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ownAddr_ff <= 5'h00;
        end else begin
            ownAddr_ff <= sar_pkg::ADDR_LUT[lutIdx]; // R3
        end
    end

    // ==================================================================
    // Byte decode
    assign byteDone   = (state_ff == ST_RX) && ln.sclFall
                        && (bitCnt_ff == sar_pkg::BITS_PER_BYTE);
    assign isAddrByte = byteDone && (byteNo_ff == sar_pkg::BYTE_ADDR);
    assign ownHit     = isAddrByte
                        && shReg_ff[7:1] == {sar_pkg::ADDR_TOP, ownAddr_ff}; // R1
    assign massHit    = isAddrByte && massWrEn && !shReg_ff[0]
                        && shReg_ff[7:1] == sar_pkg::MASS_ADDR; // R2
    assign araHit     = isAddrByte && alertOe_ff && shReg_ff[0]
                        && shReg_ff[7:1] == sar_pkg::ARA_ADDR; // R11
    assign ackGo      = ownHit || massHit || araHit
                        || (byteDone && !isAddrByte);
    assign araRel     = (state_ff == ST_MACK) && ln.sclFall && araMode_ff;
    assign araWord    = {sar_pkg::ADDR_TOP, ownAddr_ff, 1'b0}; // R11
    assign txSrc      = araMode_ff ? araWord : regRdData;
    assign rdMsb      = regRdData[7];
    assign cmdBits    = shReg_ff[2:0];

    // ==================================================================
    // Transfer engine: receive, acknowledge, transmit
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff     <= ST_IDLE;
            bitCnt_ff    <= 4'h0;
            shReg_ff     <= 8'h00;
            txByte_ff    <= 8'h00;
            byteNo_ff    <= sar_pkg::BYTE_ADDR;
            txMode_ff    <= 1'b0;
            araMode_ff   <= 1'b0;
            mAck_ff      <= 1'b0;
            sdaOe_ff     <= 1'b0;
            regPtr_ff    <= 3'h0;
            regWrEn_ff   <= 1'b0;
            regWrData_ff <= 8'h00;
        end else begin
            regWrEn_ff <= 1'b0;
            if (ln.stopCond) begin
                state_ff <= ST_IDLE; // R6
                sdaOe_ff <= 1'b0;
            end else if (ln.startCond) begin
                state_ff   <= ST_RX; // R7
                bitCnt_ff  <= 4'h0;
                byteNo_ff  <= sar_pkg::BYTE_ADDR;
                txMode_ff  <= 1'b0;
                araMode_ff <= 1'b0;
                sdaOe_ff   <= 1'b0;
            end else begin
                unique case (state_ff)
                    ST_IDLE: sdaOe_ff <= 1'b0;
                    ST_RX: begin
                        if (ln.sclRise) begin
                            shReg_ff  <= {shReg_ff[6:0], ln.sdaLvl};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end else if (byteDone && ackGo) begin
                            sdaOe_ff   <= 1'b1;
                            state_ff   <= ST_ACK;
                            txMode_ff  <= isAddrByte && shReg_ff[0];
                            araMode_ff <= araHit;
                            if (byteNo_ff != sar_pkg::BYTE_DAT2) begin
                                byteNo_ff <= byteNo_ff + 2'h1; // R5
                            end
                            if (byteNo_ff == sar_pkg::BYTE_CMD) begin
                                regPtr_ff <= cmdBits; // R4
                            end
                            if (byteNo_ff == sar_pkg::BYTE_DAT1) begin
                                regWrEn_ff   <= 1'b1;
                                regWrData_ff <= shReg_ff;
                            end
                        end else if (byteDone) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    ST_ACK: begin
                        if (ln.sclFall && txMode_ff) begin
                            sdaOe_ff  <= ~txSrc[7]; // R8
                            txByte_ff <= {txSrc[6:0], 1'b0};
                            bitCnt_ff <= 4'h1;
                            state_ff  <= ST_TX;
                        end else if (ln.sclFall) begin
                            sdaOe_ff  <= 1'b0;
                            bitCnt_ff <= 4'h0;
                            state_ff  <= ST_RX;
                        end
                    end
                    ST_TX: begin
                        if (ln.sclFall
                            && bitCnt_ff == sar_pkg::BITS_PER_BYTE) begin
                            sdaOe_ff <= 1'b0;
                            state_ff <= ST_MACK;
                        end else if (ln.sclFall) begin
                            sdaOe_ff  <= ~txByte_ff[7];
                            txByte_ff <= {txByte_ff[6:0], 1'b0};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end
                    end
                    ST_MACK: begin
                        if (ln.sclRise) begin
                            mAck_ff <= ~ln.sdaLvl;
                        end else if (ln.sclFall && mAck_ff
                                     && !araMode_ff) begin
                            sdaOe_ff  <= ~txSrc[7]; // R9
                            txByte_ff <= {txSrc[6:0], 1'b0};
                            bitCnt_ff <= 4'h1;
                            state_ff  <= ST_TX;
                        end else if (ln.sclFall) begin
                            state_ff <= ST_IDLE; // R15
                        end
                    end
                endcase
            end
        end
    end

    // ==================================================================
    // Alert: set edge of enabled flags, released by response or address
    assign newFault = faultFlags & ~flagPrev_ff & alertEnable; // R14
    // Flag history and alert pin; a new edge wins over a release
    always_ff @(posedge core_clk) begin
        if (srst) begin
            flagPrev_ff <= 8'h00;
            alertOe_ff  <= 1'b0;
            lowLvl_ff   <= 1'b0;
        end else begin
            flagPrev_ff <= faultFlags; // R13
            if (|newFault) begin
                alertOe_ff <= 1'b1; // R10
            end else if (ownHit || araRel) begin
                alertOe_ff <= 1'b0; // R12
            end
        end
    end

    assign sdaOut    = lowLvl_ff;
    assign sdaOe     = sdaOe_ff;
    assign alertOut  = lowLvl_ff;
    assign alertOe   = alertOe_ff;
    assign regPtr    = regPtr_ff;
    assign regWrEn   = regWrEn_ff;
    assign regWrData = regWrData_ff;

    // ==================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_cmdDone;
        byteDone && byteNo_ff == sar_pkg::BYTE_CMD;
    endsequence
    sequence s_araDone;
        araRel && !(|newFault);
    endsequence

    property p_own_ack;
        ownHit |=> sdaOe_ff && state_ff == ST_ACK;
    endproperty
    a_own_ack: assert property (p_own_ack) else $error("no own ack"); // R1
    property p_mass_off;
        isAddrByte && !massWrEn
        && shReg_ff == {sar_pkg::MASS_ADDR, 1'b0} |=> !sdaOe_ff;
    endproperty
    a_mass_off: assert property (p_mass_off) else $error("mass taken"); // R2
    property p_ptr_load;
        s_cmdDone |=> regPtr_ff == $past(cmdBits) ##1 !regWrEn_ff;
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("bad pointer"); // R4
    property p_second_byte;
        byteDone && byteNo_ff == sar_pkg::BYTE_DAT2
        |=> !regWrEn_ff && sdaOe_ff;
    endproperty
    a_second_byte: assert property (p_second_byte) else $error("byte 2"); // R5
    property p_tx_msb;
        state_ff == ST_ACK && ln.sclFall && txMode_ff && !araMode_ff
        |=> state_ff == ST_TX && sdaOe_ff == !$past(rdMsb);
    endproperty
    a_tx_msb: assert property (p_tx_msb) else $error("first bit"); // R8
    property p_repeat;
        state_ff == ST_MACK && ln.sclFall && mAck_ff && !araMode_ff
        |=> state_ff == ST_TX && sdaOe_ff == !$past(rdMsb);
    endproperty
    a_repeat: assert property (p_repeat) else $error("no repeat"); // R9
    property p_alert_set;
        |newFault |=> alertOe_ff;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert late"); // R10
    property p_ara_rel;
        s_araDone |=> !alertOe_ff && state_ff == ST_IDLE;
    endproperty
    a_ara_rel: assert property (p_ara_rel) else $error("alert kept"); // R11
    property p_own_rel;
        ownHit && !(|newFault) |=> !alertOe_ff;
    endproperty
    a_own_rel: assert property (p_own_rel) else $error("alert held"); // R12
    property p_no_level;
        !(|newFault) && !alertOe_ff |=> !alertOe_ff;
    endproperty
    a_no_level: assert property (p_no_level) else $error("alert raised"); // R14
endmodule
